// >>> hdl/prot_monitor.sv
// protection, temperature readout and FET control logic
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module prot_monitor
  import prot_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int NCELL       = 7
) (
  input  wire logic         CLK_IN,
  input  wire logic         RESET_IN,
  input  wire logic [7:0]   AVS_ADDRESS_IN,
  input  wire logic         AVS_READ_IN,
  input  wire logic         AVS_WRITE_IN,
  input  wire logic [31:0]  AVS_WRITEDATA_IN,
  input  wire logic [3:0]   AVS_BYTEENABLE_IN,
  output logic [31:0]       AVS_READDATA_OUT,
  output logic              AVS_WAITREQUEST_OUT,
  input  wire logic [3:0]   CUR_CMP_IN,
  input  wire logic [15:0]  ADC_RAW_IN,
  input  wire logic         ADC_VALID_IN,
  input  wire logic         ADC_IS_DIE_IN,
  input  wire logic         DIAG_FAIL_IN,
  input  wire logic [NCELL-1:0] CELL_UV_IN,
  input  wire logic         CHG_DET_IN,
  output logic              SENSE_BIAS_OUT,
  output logic              SENSE_REF_18_OUT,
  output logic              SENSE_CONVERT_OUT,
  output logic              OPEN_WIRE_EN_OUT,
  output logic              CHARGE_FET_GATE_OUT,
  output logic              DISCHARGE_FET_GATE_OUT,
  output logic              ALERT_OUT,
  output logic              SHUTDOWN_REQ_OUT
);

  initial begin
    if (TICK_CYCLES < 2 || NCELL < 2 || NCELL > 8)
      $error("prot_monitor: bad parameter");
  end

  // trim correction: offset then gain in 2.14 fixed point
  function automatic logic [15:0] trim_fn(input logic [15:0] raw,
                                          input logic [31:0] trim);
    logic signed [16:0] sum;
    logic signed [33:0] prod;
    sum  = 17'(signed'(raw)) + 17'(signed'(trim[15:0]));
    prod = 34'(sum) * 34'(signed'({1'b0, trim[31:16]}));
    return prod[GAIN_SHIFT+15:GAIN_SHIFT];
  endfunction : trim_fn

  typedef enum logic [1:0] {RUN, TRIPPED, WAIT_RETRY, LATCHED} cur_e;

  logic [31:0] ctrl_ff, prot_en_ff, fet_sel_ff, policy_ff, trim_ff;
  logic [31:0] thresh_ff, timing_ff;
  logic [NPROT-1:0] fault_ff;
  logic [NCELL-1:0] cell_flt_ff;
  logic [15:0] die_temp_ff, sense_ff;
  logic [31:0] tick_cnt_ff;
  logic        tick_ff;
  logic [15:0] wdog_cnt_ff;
  logic [15:0] retry_cnt_ff;
  logic [7:0]  retries_ff;
  logic [15:0] ow_cnt_ff;
  logic [7:0]  deb_cnt_ff;
  logic        det_deb_ff;
  logic [2:0]  bias_cnt_ff;
  logic [7:0]  pwm_cnt_ff;
  cur_e        cur_st_ff;
  logic        ack_ff;

  // bus decode
  wire logic req      = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_ff;
  wire logic wr       = AVS_WRITE_IN & ~ack_ff;
  wire logic wr_ctrl  = wr && AVS_ADDRESS_IN == ADDR_CTRL;
  wire logic wr_cmd   = wr && AVS_ADDRESS_IN == ADDR_CMD;
  wire logic host_rec = wr_cmd & AVS_WRITEDATA_IN[K_RECOVER];
  wire logic shut     = ctrl_ff[C_SHUTDOWN];
  wire logic [31:0] be_mask = {{8{AVS_BYTEENABLE_IN[3]}},
                               {8{AVS_BYTEENABLE_IN[2]}},
                               {8{AVS_BYTEENABLE_IN[1]}},
                               {8{AVS_BYTEENABLE_IN[0]}}};

  // fault sources
  wire logic [NPROT-1:0] raw_flt;
  assign raw_flt[P_OCC]    = CUR_CMP_IN[0];
  assign raw_flt[P_OCD1]   = CUR_CMP_IN[1];
  assign raw_flt[P_OCD2]   = CUR_CMP_IN[2];
  assign raw_flt[P_SC]     = CUR_CMP_IN[3];
  assign raw_flt[P_CELLV]  = |cell_flt_ff;
  assign raw_flt[P_DIE_OT] = die_temp_ff > thresh_ff[15:0];
  assign raw_flt[P_WDOG]   = wdog_cnt_ff == 16'h0000 &&
                             timing_ff[31:24] != 8'h00;
  assign raw_flt[P_DIAG]   = DIAG_FAIL_IN;
  wire logic [NPROT-1:0] new_flt = raw_flt & prot_en_ff[NPROT-1:0];

  // fault acts on FETs only when selected and policy is not alert-only
  wire logic [NPROT-1:0] acts;
  genvar gi;
  for (gi = 0; gi < NPROT; gi++) begin : g_act
    assign acts[gi] = fault_ff[gi] & fet_sel_ff[gi] &
                      (policy_ff[2*gi +: 2] != POL_ALERT);
  end
  wire logic cur_act  = |acts[P_SC:P_OCC];
  wire logic volt_act = |acts[NPROT-1:P_CELLV];

  // auto-recoverable faults other than current faults clear when the cause is gone
  wire logic [NPROT-1:0] auto_clr;
  for (gi = 0; gi < NPROT; gi++) begin : g_clr
    assign auto_clr[gi] = policy_ff[2*gi +: 2] == POL_AUTO && gi > P_SC &&
                          !raw_flt[gi];
  end

  // open wire collapse flags this cell and the one above
  wire logic [NCELL-1:0] cell_hit;
  assign cell_hit = CELL_UV_IN | (NCELL'(CELL_UV_IN) << 1);

  wire logic pwm_on = pwm_cnt_ff < timing_ff[23:16];
  wire logic ow_due = ow_cnt_ff == 16'h0000;
  wire logic det_ch = CHG_DET_IN != det_deb_ff;

  // slow tick from the system clock
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 32'h00000000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
    end
    tick_ff <= !RESET_IN && tick_cnt_ff == 32'(TICK_CYCLES - 1);
  end

  // avalon slave: one wait state, answer on second edge
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // register writes; shutdown wipes settings
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || shut) begin
      ctrl_ff    <= CTRL_RST;
      prot_en_ff <= PROT_EN_RST;
      fet_sel_ff <= FET_SEL_RST;
      policy_ff  <= 32'h00000000;
      trim_ff    <= TRIM_RST;
      thresh_ff  <= {16'h0000, DIE_OT_RST};
      timing_ff  <= 32'h80FF1010;
    end else if (wr) begin
      if (wr_ctrl)
        ctrl_ff <= (ctrl_ff & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
      if (AVS_ADDRESS_IN == ADDR_PROT_EN)
        prot_en_ff <= (prot_en_ff & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
      if (AVS_ADDRESS_IN == ADDR_FET_SEL)
        fet_sel_ff <= (fet_sel_ff & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
      if (AVS_ADDRESS_IN == ADDR_POLICY)
        policy_ff <= (policy_ff & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
      if (AVS_ADDRESS_IN == ADDR_TRIM)
        trim_ff <= (trim_ff & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
      if (AVS_ADDRESS_IN == ADDR_THRESH)
        thresh_ff <= (thresh_ff & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
      if (AVS_ADDRESS_IN == ADDR_TIMING)
        timing_ff <= (timing_ff & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
    end
  end

  // host watchdog, reloaded by every bus transaction
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || shut || req) begin
      wdog_cnt_ff <= {8'h00, timing_ff[31:24]};
    end else if (tick_ff && wdog_cnt_ff != 16'h0000) begin
      wdog_cnt_ff <= wdog_cnt_ff - 16'h0001;
    end
  end

  // fault flags: set wins over host clear
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || shut) begin
      fault_ff    <= '0;
      cell_flt_ff <= '0;
    end else begin
      fault_ff <= (fault_ff & ~auto_clr &
                   ~(host_rec ? {NPROT{1'b1}} : {NPROT{1'b0}})) | new_flt;
      cell_flt_ff <= (cell_flt_ff & ~(host_rec ? cell_hit | ~cell_hit
                                                : {NCELL{1'b0}}))
                     | cell_hit;
    end
  end

  // sense and die measurement with trim and bias windows
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || shut) begin
      die_temp_ff <= 16'h0000;
      sense_ff    <= 16'h0000;
      bias_cnt_ff <= 3'h0;
    end else begin
      if (ADC_VALID_IN && ADC_IS_DIE_IN)
        die_temp_ff <= trim_fn(ADC_RAW_IN, trim_ff);
      if (ADC_VALID_IN && !ADC_IS_DIE_IN)
        sense_ff <= trim_fn(ADC_RAW_IN, trim_ff);
      if (tick_ff && bias_cnt_ff == 3'h0)
        bias_cnt_ff <= SENSE_BIAS_TICKS;
      else if (tick_ff)
        bias_cnt_ff <= bias_cnt_ff - 3'h1;
    end
  end

  // conversion window outputs for the sense pin
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || shut) begin
      SENSE_CONVERT_OUT <= 1'b0;
      SENSE_BIAS_OUT    <= 1'b0;
      SENSE_REF_18_OUT  <= 1'b1;
    end else begin
      SENSE_CONVERT_OUT <= bias_cnt_ff == 3'h1;
      SENSE_BIAS_OUT    <= bias_cnt_ff == 3'h1 &&
                           !ctrl_ff[C_TS_ANALOG];
      SENSE_REF_18_OUT  <= !ctrl_ff[C_TS_ANALOG];
    end
  end

  // current fault recovery with retry latch
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || shut) begin
      cur_st_ff    <= RUN;
      retry_cnt_ff <= 16'h0000;
      retries_ff   <= 8'h00;
    end else begin
      unique case (cur_st_ff)
        RUN: if (cur_act) cur_st_ff <= TRIPPED;
        TRIPPED: begin
          retry_cnt_ff <= {8'h00, timing_ff[7:0]};
          if (ctrl_ff[C_LATCH_EN] && retries_ff >= timing_ff[15:8])
            cur_st_ff <= LATCHED;
          else if (policy_ff[1:0] == POL_AUTO)
            cur_st_ff <= WAIT_RETRY;
        end
        WAIT_RETRY: begin
          if (tick_ff && retry_cnt_ff != 16'h0000)
            retry_cnt_ff <= retry_cnt_ff - 16'h0001;
          if (retry_cnt_ff == 16'h0000) begin
            retries_ff <= retries_ff + 8'h01;
            cur_st_ff  <= RUN;
          end
        end
        LATCHED: ;
      endcase
      if (host_rec) begin
        cur_st_ff  <= RUN;
        retries_ff <= 8'h00;
      end
    end
  end

  // open wire pacing and detector debounce
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || shut) begin
      ow_cnt_ff        <= 16'h0000;
      OPEN_WIRE_EN_OUT <= 1'b0;
      deb_cnt_ff       <= 8'h00;
      det_deb_ff       <= 1'b0;
      pwm_cnt_ff       <= 8'h00;
    end else begin
      pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
      // reload with interval minus one so pulses are interval ticks apart
      if (tick_ff && ow_due && thresh_ff[31:24] != 8'h00)
        ow_cnt_ff <= {8'h00, thresh_ff[31:24]} - 16'h0001;
      else if (tick_ff && !ow_due)
        ow_cnt_ff <= ow_cnt_ff - 16'h0001;
      OPEN_WIRE_EN_OUT <= tick_ff && ow_due && thresh_ff[31:24] != 8'h00;
      if (!det_ch)
        deb_cnt_ff <= 8'h00;
      else if (tick_ff)
        deb_cnt_ff <= deb_cnt_ff + 8'h01;
      if (det_ch && deb_cnt_ff >= DEBOUNCE_TICKS) begin
        det_deb_ff <= CHG_DET_IN;
        deb_cnt_ff <= 8'h00;
      end
    end
  end

  // FET gates, alert and shutdown request
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || shut) begin
      CHARGE_FET_GATE_OUT    <= 1'b0;
      DISCHARGE_FET_GATE_OUT <= 1'b0;
      ALERT_OUT              <= 1'b0;
      SHUTDOWN_REQ_OUT       <= shut;
    end else begin
      DISCHARGE_FET_GATE_OUT <= cur_st_ff == RUN && !volt_act &&
                                (!ctrl_ff[C_PWM_EN] || pwm_on);
      CHARGE_FET_GATE_OUT <= !volt_act &&
        (cur_st_ff == RUN || !ctrl_ff[C_CHG_ON_CUR]) &&
        (ctrl_ff[C_PARALLEL] || cur_st_ff == RUN) &&
        (!ctrl_ff[C_PWM_EN] || pwm_on);
      if (|fault_ff || (ctrl_ff[C_DET_ALERT] && det_ch &&
                        deb_cnt_ff >= DEBOUNCE_TICKS))
        ALERT_OUT <= 1'b1;
      else if (wr_cmd && AVS_WRITEDATA_IN[K_CLR_ALERT])
        ALERT_OUT <= 1'b0;
      SHUTDOWN_REQ_OUT <= fault_ff[P_DIE_OT] && ctrl_ff[C_OT_SHUT];
    end
  end

  // read data mux
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      AVS_READDATA_OUT <= 32'h00000000;
    end else if (AVS_READ_IN && !ack_ff) begin
      unique case (AVS_ADDRESS_IN)
        ADDR_CTRL:    AVS_READDATA_OUT <= ctrl_ff;
        ADDR_PROT_EN: AVS_READDATA_OUT <= prot_en_ff;
        ADDR_FET_SEL: AVS_READDATA_OUT <= fet_sel_ff;
        ADDR_POLICY:  AVS_READDATA_OUT <= policy_ff;
        ADDR_TRIM:    AVS_READDATA_OUT <= trim_ff;
        ADDR_THRESH:  AVS_READDATA_OUT <= thresh_ff;
        ADDR_TIMING:  AVS_READDATA_OUT <= timing_ff;
        ADDR_FAULT:   AVS_READDATA_OUT <= {24'h000000, fault_ff};
        ADDR_STATUS:  AVS_READDATA_OUT <= {16'h0000, retries_ff, 3'h0,
                        det_deb_ff, CHG_DET_IN, ALERT_OUT,
                        2'(cur_st_ff)};
        ADDR_TEMP:    AVS_READDATA_OUT <= {16'h0000, die_temp_ff};
        ADDR_SENSE:   AVS_READDATA_OUT <= {16'h0000, sense_ff};
        ADDR_CELLFLT: AVS_READDATA_OUT <= 32'(cell_flt_ff);
        default:      AVS_READDATA_OUT <= BAD_ADDR_DATA;
      endcase
    end
  end

  // waitrequest high until the answer edge
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      AVS_WAITREQUEST_OUT <= !req;
    end
  end

endmodule : prot_monitor

// >>> hdl/prot_pkg.sv
// constants for the battery protection monitor
//
// Behaviour
// - die temperature sampled each loop and readable by host.
// - die temperature over threshold may drop FETs and request shutdown.
// - a config bit picks thermistor or general analog input mode.
// - thermistor mode biases pin only during conversion, uses 1.8 V reference.
// - analog input mode keeps bias off and uses primary bandgap reference.
// - sense pin result is signed 16-bit count, full scale ref times 5/3.
// - raw readings corrected by writable offset and gain trim before reporting.
// - each protection has an enable and a separate FET-control select.
// - policies are auto recovery, host recovery, or alert only.
// - current faults come from comparators, others from converter or logic.
// - host watchdog expiry is a protection fault that can act on FETs.
// - FET drivers support series or parallel and PWM drive.
// - diagnostic failures may drive FET enables per configuration.
// - charge detector raw state readable; debounced toggle raises alert.
// - current fault drops discharge FET, charge per setting, retries after delay.
// - current latch stops automatic retries after configured attempt count.
// - open-wire test current enabled at periodic configured interval.
// - open-wire collapse faults the affected cell and the cell above.
// - shutdown holds FETs off, stops protections, measurements, clears registers; here this lasts one clock, as the shutdown bit is cleared too.
package prot_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PROT_EN  = 8'h04;
  localparam logic [7:0] ADDR_FET_SEL  = 8'h08;
  localparam logic [7:0] ADDR_POLICY   = 8'h0C;
  localparam logic [7:0] ADDR_TRIM     = 8'h10;
  localparam logic [7:0] ADDR_THRESH   = 8'h14;
  localparam logic [7:0] ADDR_TIMING   = 8'h18;
  localparam logic [7:0] ADDR_FAULT    = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_TEMP     = 8'h24;
  localparam logic [7:0] ADDR_SENSE    = 8'h28;
  localparam logic [7:0] ADDR_CMD      = 8'h2C;
  localparam logic [7:0] ADDR_CELLFLT  = 8'h30;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hDEADBEEF;

  // protection bit positions
  localparam int NPROT       = 8;
  localparam int P_OCC       = 0;
  localparam int P_OCD1      = 1;
  localparam int P_OCD2      = 2;
  localparam int P_SC        = 3;
  localparam int P_CELLV     = 4;
  localparam int P_DIE_OT    = 5;
  localparam int P_WDOG      = 6;
  localparam int P_DIAG      = 7;

  // control register fields
  localparam int C_TS_ANALOG = 0;
  localparam int C_PARALLEL  = 1;
  localparam int C_PWM_EN    = 2;
  localparam int C_CHG_ON_CUR = 3;
  localparam int C_OT_SHUT   = 4;
  localparam int C_DET_ALERT = 5;
  localparam int C_LATCH_EN  = 6;
  localparam int C_SHUTDOWN  = 7;

  // command register fields
  localparam int K_RECOVER   = 0;
  localparam int K_CLR_ALERT = 1;

  // policy codes per protection, two bits each
  localparam logic [1:0] POL_AUTO  = 2'h0;
  localparam logic [1:0] POL_HOST  = 2'h1;
  localparam logic [1:0] POL_ALERT = 2'h2;

  // reset values
  localparam logic [31:0] CTRL_RST    = 32'h00000008;
  localparam logic [31:0] PROT_EN_RST = 32'h000000FF;
  localparam logic [31:0] FET_SEL_RST = 32'h000000FF;
  localparam logic [31:0] TRIM_RST    = 32'h40000000; // gain 1.0, offset 0
  localparam logic [15:0] DIE_OT_RST  = 16'h0078;
  localparam int GAIN_SHIFT = 14;

  // timing defaults; debounce and bias counts in slow ticks
  localparam real CLK_NS       = 8.0;
  localparam real TICK_US      = 1000.0;
  localparam int  TICK_CYC     = int'(TICK_US * 1000.0 / CLK_NS);
  localparam logic [7:0] DEBOUNCE_TICKS = 8'h04;
  localparam logic [2:0] SENSE_BIAS_TICKS = 3'h2;
endpackage : prot_pkg

// >>> test/host_master.sv
// bus master model standing in for the host processor
`timescale 1ns/10ps
module host_master (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        go_in,
  input  wire logic        wr_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        waitreq_in,
  input  wire logic [31:0] readdata_in,
  output logic             read_out,
  output logic             write_out,
  output logic [7:0]       address_out,
  output logic [31:0]      writedata_out,
  output logic [3:0]       byteenable_out,
  output logic [31:0]      rdata_out,
  output logic             done_out
);
  wire logic busy = read_out | write_out;
  // issue, hold until waitrequest low, then release
  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    if (rst_in) begin
      read_out       <= 1'b0;
      write_out      <= 1'b0;
      address_out    <= 8'h00;
      writedata_out  <= 32'h0;
      byteenable_out <= 4'h0;
    end else if (busy && !waitreq_in) begin
      read_out       <= 1'b0;
      write_out      <= 1'b0;
      address_out    <= ~address_out; // released lines toggle
      writedata_out  <= ~writedata_out;
      byteenable_out <= ~byteenable_out;
      rdata_out      <= readdata_in;
      done_out       <= 1'b1;
    end else if (go_in && !busy) begin
      read_out       <= !wr_in;
      write_out      <= wr_in;
      address_out    <= addr_in;
      writedata_out  <= wdata_in;
      byteenable_out <= 4'hF;
    end
  end
endmodule : host_master

// >>> test/prot_monitor_checker.sv
// port assertions for the protection monitor
`timescale 1ns/10ps
module prot_monitor_checker
  import prot_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        RESET_IN,
  input wire logic [7:0]  AVS_ADDRESS_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  input wire logic        SENSE_BIAS_OUT,
  input wire logic        SENSE_REF_18_OUT,
  input wire logic        SENSE_CONVERT_OUT,
  input wire logic        OPEN_WIRE_EN_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  // bus request taken, then a one-cycle answer
  sequence s_req;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
  endsequence
  sequence s_ack;
    ##1 !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
  endsequence
  property p_ack;
    s_req |-> s_ack;
  endproperty
  property p_idle;
    !(AVS_READ_IN || AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT;
  endproperty
  property p_unmapped;
    AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 8'hFC
      |-> AVS_READDATA_OUT == BAD_ADDR_DATA;
  endproperty
  property p_rd_hold;
    !AVS_READ_IN |=> $stable(AVS_READDATA_OUT);
  endproperty
  // sense pin bias follows the selected mode
  property p_bias_therm;
    SENSE_CONVERT_OUT && SENSE_REF_18_OUT |-> SENSE_BIAS_OUT;
  endproperty
  property p_bias_analog;
    SENSE_CONVERT_OUT && !SENSE_REF_18_OUT |-> !SENSE_BIAS_OUT;
  endproperty
  property p_bias_rose;
    $rose(SENSE_BIAS_OUT) |-> SENSE_REF_18_OUT;
  endproperty
  property p_ow_pulse;
    $rose(OPEN_WIRE_EN_OUT) |=> !OPEN_WIRE_EN_OUT;
  endproperty

  a_ack: assert property (p_ack)
    else $error("bus answer not one cycle after request");
  a_idle: assert property (p_idle)
    else $error("waitrequest low without request");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read data wrong");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without read");
  a_bias_therm: assert property (p_bias_therm)
    else $error("bias off in thermistor conversion");
  a_bias_analog: assert property (p_bias_analog)
    else $error("bias on in analog conversion");
  a_bias_rose: assert property (p_bias_rose)
    else $error("bias raised in analog mode");
  a_ow_pulse: assert property (p_ow_pulse)
    else $error("open wire enable longer than one cycle");
endmodule : prot_monitor_checker

bind prot_monitor prot_monitor_checker prot_monitor_checker_i (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .SENSE_BIAS_OUT(SENSE_BIAS_OUT), .SENSE_REF_18_OUT(SENSE_REF_18_OUT),
  .SENSE_CONVERT_OUT(SENSE_CONVERT_OUT),
  .OPEN_WIRE_EN_OUT(OPEN_WIRE_EN_OUT));

// >>> test/prot_monitor_tb.sv
// self-checking bench for the protection monitor
`timescale 1ns/10ps
module prot_monitor_tb
  import prot_pkg::*;
;
  localparam int TICK = 4;
  typedef struct packed {
    logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;
  } row_s;
  logic        clk, rst, go, wr, done, read, write, waitreq;
  logic [7:0]  addr, address;
  logic [31:0] wdata, rdata, readdata, writedata;
  logic [3:0]  cur_cmp, byteen;
  logic [15:0] adc_raw;
  logic        adc_valid, adc_die, diag, chg_det, last;
  logic [6:0]  cell_uv;
  logic        bias, ref18, conv, ow, chg_g, dsg_g, alert, shut;
  int          num_errors, samples_checked, n;
  row_s        rows [9] = '{
    '{1'b0, ADDR_CTRL, 32'h0, CTRL_RST},
    '{1'b0, ADDR_PROT_EN, 32'h0, PROT_EN_RST},
    '{1'b0, ADDR_FET_SEL, 32'h0, FET_SEL_RST},
    '{1'b0, ADDR_TRIM, 32'h0, TRIM_RST},
    '{1'b0, 8'hFC, 32'h0, BAD_ADDR_DATA},
    '{1'b1, 8'hFC, 32'h1, BAD_ADDR_DATA},
    '{1'b1, ADDR_TRIM, 32'h40000010, 32'h40000010},
    '{1'b1, ADDR_POLICY, 32'h00000021, 32'h00000021},
    '{1'b1, ADDR_CTRL, 32'h00000009, 32'h00000009}};

  prot_monitor #(.TICK_CYCLES(TICK), .NCELL(7)) prot_monitor_i (
    .CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(address),
    .AVS_READ_IN(read), .AVS_WRITE_IN(write), .AVS_WRITEDATA_IN(writedata),
    .AVS_BYTEENABLE_IN(byteen), .AVS_READDATA_OUT(readdata),
    .AVS_WAITREQUEST_OUT(waitreq), .CUR_CMP_IN(cur_cmp),
    .ADC_RAW_IN(adc_raw), .ADC_VALID_IN(adc_valid), .ADC_IS_DIE_IN(adc_die),
    .DIAG_FAIL_IN(diag), .CELL_UV_IN(cell_uv), .CHG_DET_IN(chg_det),
    .SENSE_BIAS_OUT(bias), .SENSE_REF_18_OUT(ref18),
    .SENSE_CONVERT_OUT(conv), .OPEN_WIRE_EN_OUT(ow),
    .CHARGE_FET_GATE_OUT(chg_g), .DISCHARGE_FET_GATE_OUT(dsg_g),
    .ALERT_OUT(alert), .SHUTDOWN_REQ_OUT(shut));
  host_master host_master_i (
    .clk_in(clk), .rst_in(rst), .go_in(go), .wr_in(wr), .addr_in(addr),
    .wdata_in(wdata), .waitreq_in(waitreq), .readdata_in(readdata),
    .read_out(read), .write_out(write), .address_out(address),
    .writedata_out(writedata), .byteenable_out(byteen),
    .rdata_out(rdata), .done_out(done));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1);
    chk({31'h0, done}, 32'h1, "bus answer");
  endtask : acc
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({27'h0, chg_g, dsg_g, alert, waitreq, ref18}, 32'h3, "reset levels");
    @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task sample(input logic die, input logic [15:0] raw);
    @(posedge clk);
    adc_valid <= 1'b1;
    adc_die <= die;
    adc_raw <= raw;
    @(posedge clk);
    adc_valid <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : sample
  task gates(input logic [1:0] e, input string s);
    chk({30'h0, chg_g, dsg_g}, {30'h0, e}, s);
  endtask : gates
  task end_sim;
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    {rst, go, wr, addr, wdata, cur_cmp, adc_raw} = '0;
    {adc_valid, adc_die, diag, chg_det, cell_uv} = '0;
    rst = 1'b1;
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].w) acc(1'b1, rows[i].a, rows[i].d);
      acc(1'b0, rows[i].a, 32'h0);
      chk(rdata, rows[i].e, "register");
    end
    chk({31'h0, ref18}, 32'h0, "analog ref");
    // short circuit with a long retry delay
    do_reset();
    acc(1'b1, ADDR_TIMING, 32'h000000FF);
    repeat (20) @(posedge clk);
    gates(2'b11, "gates on");
    cur_cmp <= 4'h8;
    repeat (40) @(posedge clk);
    gates(2'b00, "short trip");
    // latched retries, then host recovery
    do_reset();
    acc(1'b1, ADDR_TIMING, 32'h00000202);
    acc(1'b1, ADDR_CTRL, 32'h00000048);
    last = 1'b1;
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (dsg_g && !last) n++;
      last = dsg_g;
    end
    chk(32'(n), 32'h2, "retry count");
    @(posedge clk);
    cur_cmp <= 4'h0;
    repeat (60) @(posedge clk);
    gates(2'b00, "latched off");
    acc(1'b1, ADDR_CMD, 32'h1);
    repeat (60) @(posedge clk);
    chk({31'h0, dsg_g}, 32'h1, "recovered");
    // trimmed readout and die overtemperature boundary
    do_reset();
    acc(1'b1, ADDR_TIMING, 32'h000000FF);
    acc(1'b1, ADDR_TRIM, 32'h40000010);
    acc(1'b1, ADDR_CTRL, 32'h00000018);
    acc(1'b1, ADDR_THRESH, 32'h00000100);
    sample(1'b0, 16'h1234);
    acc(1'b0, ADDR_SENSE, 32'h0);
    chk({16'h0, rdata[15:0]}, 32'h1244, "sense");
    sample(1'b1, 16'h00F0);
    acc(1'b0, ADDR_TEMP, 32'h0);
    chk({16'h0, rdata[15:0]}, 32'h0100, "die temp");
    gates(2'b11, "at threshold");
    sample(1'b1, 16'h00F1);
    chk({30'h0, chg_g | dsg_g, shut}, 32'h1, "over temp");
    // detector alert, open wire interval and cell pair
    do_reset();
    acc(1'b1, ADDR_TIMING, 32'h000000FF);
    acc(1'b1, ADDR_CTRL, 32'h00000028);
    chg_det <= 1'b1;
    repeat (60) @(posedge clk);
    chk({31'h0, alert}, 32'h1, "alert");
    acc(1'b1, ADDR_CMD, 32'h2);
    repeat (5) @(posedge clk);
    chk({31'h0, alert}, 32'h0, "alert clear");
    acc(1'b1, ADDR_THRESH, 32'h02000078);
    repeat (2) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (ow !== 1'b1 && n < 100);
    end
    chk(32'(n), 32'(2 * TICK), "open wire gap");
    @(posedge clk);
    cell_uv <= 7'h04;
    repeat (20) @(posedge clk);
    acc(1'b0, ADDR_CELLFLT, 32'h0);
    chk({29'h0, rdata[3:1]}, 32'h6, "cell pair");
    cell_uv <= 7'h00;
    // watchdog kept alive, then left to expire
    do_reset();
    acc(1'b1, ADDR_TIMING, 32'h080000FF);
    repeat (6) begin
      repeat (15) @(posedge clk);
      acc(1'b0, ADDR_TEMP, 32'h0);
    end
    chk({31'h0, dsg_g}, 32'h1, "watchdog fed");
    repeat (80) @(posedge clk);
    chk({31'h0, dsg_g}, 32'h0, "watchdog expiry");
    end_sim();
  end
endmodule : prot_monitor_tb
